// >>> rtl/serial_flash_pin_interface.sv
// Pin-level serial interface of a serial flash: framing, sampling, output drive, write-protect
`timescale 1ns/10ps
`include "flash_pin_consts.svh"


module serial_flash_pin_interface #(
  parameter int unsigned PROG_CYCLES = `PROG_TIME_US * `CORE_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe,
  output logic standby,
  output logic busy,
  output logic op_start,
  output logic op_discard
);

  import flash_pin_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: shifting on the serial clock

  logic [`BIT_CNT_W-1:0] bit_cnt;
  logic [`FRAME_BITS-1:0] shift_in;
  logic [`OPCODE_BITS-1:0] opcode;
  logic [`FRAME_BITS-1:0] frame_word;
  logic [`BIT_CNT_W-1:0] frame_bits;
  logic [`OPCODE_BITS-1:0] so_shift;
  logic busy_meta;
  logic busy_link;
  logic prot_meta;
  logic prot_link;
  logic wpl_meta;
  logic wpl_link;
  logic [`OPCODE_BITS-1:0] status_byte;
  logic prot_enable;

  // Select high holds the shifter in reset, so a new frame always starts clean
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= '0;
      shift_in <= '0;
      opcode <= '0;
    end else begin
      shift_in <= {shift_in[`FRAME_BITS-2:0], si};
      if (bit_cnt != `BIT_CNT_FULL) begin
        bit_cnt <= bit_cnt + `BIT_CNT_ONE;
      end
      if (bit_cnt == `OPCODE_LAST_BIT) begin
        opcode <= {shift_in[`OPCODE_BITS-2:0], si};
      end
    end
  end

  // Frame snapshot survives select rising; clock stands still until the next frame
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      frame_word <= '0;
      frame_bits <= '0;
    end else if (!cs_n) begin
      frame_word <= {shift_in[`FRAME_BITS-2:0], si};
      frame_bits <= (bit_cnt == `BIT_CNT_FULL) ? bit_cnt : bit_cnt + `BIT_CNT_ONE;
    end
  end

  // Core status levels and the write-protect pin into the link domain
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      busy_meta <= 1'b0;
      busy_link <= 1'b0;
      prot_meta <= 1'b0;
      prot_link <= 1'b0;
      wpl_meta <= 1'b0;
      wpl_link <= 1'b0;
    end else begin
      busy_meta <= busy;
      busy_link <= busy_meta;
      prot_meta <= prot_enable;
      prot_link <= prot_meta;
      wpl_meta <= wp_n;
      wpl_link <= wpl_meta;
    end
  end

  always_comb begin
    status_byte = '0;
    status_byte[`STATUS_BUSY_BIT] = busy_link;
    status_byte[`STATUS_PROT_EN_BIT] = prot_link;
    status_byte[`STATUS_WP_BIT] = ~wpl_link;
  end

  // Output shifter on the falling edge; select high floats the pin at once
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_oe <= 1'b0;
      so_shift <= '0;
    end else if (bit_cnt == `OPCODE_DONE && opcode == `OP_READ_STATUS) begin
      so_oe <= 1'b1;
      so_shift <= status_byte;
    end else begin
      so_shift <= {so_shift[`OPCODE_BITS-2:0], 1'b0};
    end
  end

  assign so_out = so_shift[`OPCODE_BITS-1];

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: select and write-protect synchronisers

  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic wp_meta;
  logic wp_sync;
  logic frame_begin;
  logic frame_end;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      wp_meta <= wp_n;
      wp_sync <= wp_meta;
    end
  end

  assign frame_begin = cs_prev & ~cs_sync;
  assign frame_end = ~cs_prev & cs_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: command decision and self-timed operation

  core_state_t state;
  logic [`OPCODE_BITS-1:0] cmd_op;
  logic [`SECTOR_IDX_W-1:0] cmd_sector;
  logic cmd_full;
  logic [`TIMER_W-1:0] timer;
  logic [`MAP_W-1:0] map_word;
  logic map_wr_en;
  logic [`MAP_W-1:0] map_wr_data;
  logic is_modify;
  logic sector_guarded;
  logic blocked;

  assign is_modify = (cmd_op == `OP_PAGE_PROGRAM) || (cmd_op == `OP_SECTOR_ERASE);

  // Hardware pin alone suffices; protection-enable state alone suffices as well
  assign sector_guarded = map_word[`MAP_PROTECT_BIT] &
    (~wp_sync | prot_enable);
  assign blocked = map_word[`MAP_LOCK_BIT] | sector_guarded;

  sector_map_mem u_map (
    .core_clk(core_clk),
    .rstn(rstn),
    .rd_idx(cmd_sector),
    .rd_data(map_word),
    .wr_en(map_wr_en),
    .wr_idx(cmd_sector),
    .wr_data(map_wr_data)
  );

  // Frame snapshot is stable here: no serial clock edges while deselected
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_op <= '0;
      cmd_sector <= '0;
      cmd_full <= 1'b0;
    end else if (frame_end && state == ST_IDLE) begin
      cmd_op <= frame_word[`FRAME_BITS-1 -: `OPCODE_BITS];
      cmd_sector <= frame_word[`SECTOR_IDX_HI:`SECTOR_IDX_LO];
      cmd_full <= (frame_bits == `BIT_CNT_FULL);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (frame_end) begin
            state <= ST_LOOKUP;
          end
        end
        ST_LOOKUP: begin
          state <= ST_DECIDE;
        end
        ST_DECIDE: begin
          if (is_modify && cmd_full && !blocked) begin
            state <= ST_BUSY;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_BUSY: begin
          if (timer == '0) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timer <= '0;
    end else if (state == ST_DECIDE) begin
      timer <= `TIMER_W'(PROG_CYCLES - 1);
    end else if (state == ST_BUSY && timer != '0) begin
      timer <= timer - `TIMER_W'(1);
    end
  end

  // Enable and lock run even under write-protect; disable is refused then
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prot_enable <= 1'b0;
    end else if (state == ST_DECIDE && cmd_op == `OP_PROT_ENABLE) begin
      prot_enable <= 1'b1;
    end else if (state == ST_DECIDE && cmd_op == `OP_PROT_DISABLE && wp_sync) begin
      prot_enable <= 1'b0;
    end
  end

  always_comb begin
    map_wr_en = 1'b0;
    map_wr_data = `MAP_RESET;
    if (state == ST_DECIDE && cmd_full) begin
      if (cmd_op == `OP_SECTOR_LOCK) begin
        map_wr_en = 1'b1;
        map_wr_data = `MAP_LOCK_SET;
      end else if (cmd_op == `OP_SECTOR_PROTECT) begin
        map_wr_en = 1'b1;
        map_wr_data = `MAP_PROTECT_SET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: registered status outputs

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      op_start <= 1'b0;
      op_discard <= 1'b0;
    end else begin
      op_start <= (state == ST_DECIDE) && is_modify && cmd_full && !blocked;
      op_discard <= (state == ST_DECIDE) && is_modify && cmd_full && blocked;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else begin
      busy <= (state == ST_BUSY) || (state == ST_DECIDE && is_modify && cmd_full && !blocked);
    end
  end

  // Decode of the last frame must finish too, else standby flickers between states
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      standby <= 1'b1;
    end else if (frame_begin || !cs_sync) begin
      standby <= 1'b0;
    end else begin
      standby <= (state == ST_IDLE) && !frame_end;
    end
  end

endmodule : serial_flash_pin_interface

// >>> shared/flash_pin_consts.svh
// Constants for the serial flash pin interface: opcodes, framing, map layout, timing
`ifndef FLASH_PIN_CONSTS_SVH
`define FLASH_PIN_CONSTS_SVH

// Frame layout: one opcode byte, then a 24-bit address
`define OPCODE_BITS 8
`define ADDR_BITS 24
`define FRAME_BITS 32
`define BIT_CNT_W 6
`define BIT_CNT_ONE 6'h01
`define BIT_CNT_FULL 6'h20
`define OPCODE_LAST_BIT 6'h07
`define OPCODE_DONE 6'h08

// Opcodes (plain defaults)
`define OP_READ_STATUS 8'h05
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_PROT_ENABLE 8'h3D
`define OP_PROT_DISABLE 8'h3E
`define OP_SECTOR_PROTECT 8'h36
`define OP_SECTOR_LOCK 8'h7F

// Sector protection map: 8 sectors of 64 KB, one word per sector
`define SECTOR_COUNT 8
`define SECTOR_IDX_W 3
`define SECTOR_IDX_HI 18
`define SECTOR_IDX_LO 16
`define MAP_W 2
`define MAP_PROTECT_BIT 0
`define MAP_LOCK_BIT 1
`define MAP_RESET 2'h0
`define MAP_PROTECT_SET 2'h1
`define MAP_LOCK_SET 2'h3

// Status byte returned on the serial output
`define STATUS_BUSY_BIT 7
`define STATUS_PROT_EN_BIT 1
`define STATUS_WP_BIT 0

// Self-timed program or erase time
`define PROG_TIME_US 1000
`define CORE_CLK_MHZ 250
`define TIMER_W 32

`endif

// >>> shared/flash_pin_pkg.sv
// Types shared by the serial flash pin interface
package flash_pin_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_DECIDE,
    ST_BUSY
  } core_state_t;

endpackage : flash_pin_pkg

// >>> rtl/sector_map_mem.sv
// Sector protection map: one word per sector, registered read port
`timescale 1ns/10ps
`include "flash_pin_consts.svh"

module sector_map_mem (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [`SECTOR_IDX_W-1:0] rd_idx,
  output logic [`MAP_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [`SECTOR_IDX_W-1:0] wr_idx,
  input wire logic [`MAP_W-1:0] wr_data
);

  logic [`MAP_W-1:0] entry [`SECTOR_COUNT];

  genvar g;
  generate
    for (g = 0; g < `SECTOR_COUNT; g++) begin : g_entry
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          entry[g] <= `MAP_RESET;
        end else if (wr_en && (wr_idx == `SECTOR_IDX_W'(g))) begin
          // Lock is sticky: bits are only ever set
          entry[g] <= entry[g] | wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= `MAP_RESET;
    end else begin
      rd_data <= entry[rd_idx];
    end
  end

endmodule : sector_map_mem

// >>> verification/flash_pin_chk.sv
// Checker for the serial flash pin interface
`timescale 1ns/10ps
module flash_pin_chk #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic standby,
  input wire logic busy,
  input wire logic op_start,
  input wire logic op_discard
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  int unsigned busy_cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) busy_cnt <= 0;
    else busy_cnt <= busy ? busy_cnt + 1 : 0;
  end
  property p_so_hiz; cs_n |-> !so_oe; endproperty
  a_so_hiz: assert property (p_so_hiz) else $error("output driven while deselected");
  property p_sel_active; !cs_n [*5] |-> !standby; endproperty
  a_sel_active: assert property (p_sel_active) else $error("standby while selected");
  // Busy rises with the start pulse and falls one cycle after the core leaves ST_BUSY
  property p_busy_len; $fell(busy) |-> busy_cnt == PROG_CYCLES + 1; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_stby; busy |-> !standby; endproperty
  a_busy_stby: assert property (p_busy_stby) else $error("standby during busy");
  property p_stby_ret; $fell(busy) && cs_n |-> ##[1:3] standby; endproperty
  a_stby_ret: assert property (p_stby_ret) else $error("standby not resumed");
  property p_start_busy; op_start |-> busy && !standby; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_start_pulse; op_start |=> !op_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_disc_idle; op_discard |-> !busy && !op_start ##1 !busy; endproperty
  a_disc_idle: assert property (p_disc_idle) else $error("discard started work");
  property p_disc_pulse; op_discard |=> !op_discard; endproperty
  a_disc_pulse: assert property (p_disc_pulse) else $error("discard pulse too long");
endmodule : flash_pin_chk

bind serial_flash_pin_interface flash_pin_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (
  .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .so_oe(so_oe), .standby(standby),
  .busy(busy), .op_start(op_start), .op_discard(op_discard));

// >>> verification/flash_host.sv
// Host controller model: frames, serial clock and data
`timescale 1ns/10ps
module flash_host (
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  logic [7:0] rx;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    rx = 8'h00;
  end
  // Clock stands low between frames; odd offset keeps phase unrelated to core
  task automatic xfer(input logic [31:0] word, input int nbits);
    #1.3 cs_n = 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      si = word[i];
      #32 sck = 1'b1;
      rx = {rx[6:0], so_oe ? so_out : 1'bx};
      #32 sck = 1'b0;
    end
    #32 cs_n = 1'b1;
    si = ~si;
  endtask : xfer
endmodule : flash_host

// >>> verification/testbench.sv
// Self-checking bench for the serial flash pin interface
`timescale 1ns/10ps
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic wp_n = 1'b1;
  logic cs_n, sck, si, so_out, so_oe, standby, busy, op_start, op_discard;
  int err_total = 0;
  int total_checks = 0;
  int n_start = 0;
  int n_disc = 0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (op_start === 1'b1) n_start++;
    if (op_discard === 1'b1) n_disc++;
  end
  serial_flash_pin_interface #(.PROG_CYCLES(20)) DUT (.core_clk(core_clk), .rstn(rstn),
    .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
    .standby(standby), .busy(busy), .op_start(op_start), .op_discard(op_discard));
  flash_host host (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic t_status(input logic [7:0] exp);
    host.xfer({8'h05, 24'h000000}, 16);
    // Keeps the deselect gap and lets the release of the pin settle
    repeat (8) @(posedge core_clk);
    check("status", host.rx, exp);
    check("so_oe", {7'h00, so_oe}, 8'h00);
  endtask : t_status
  // Frame ending, then counts of start and discard pulses, then return to standby
  task automatic t_cmd(input logic [7:0] op, input logic [2:0] sec, input int nbits,
                       input logic [7:0] exp_s, input logic [7:0] exp_d);
    int s0;
    int d0;
    s0 = n_start;
    d0 = n_disc;
    host.xfer({op, 5'h00, sec, 16'h0000}, nbits);
    repeat (12) @(posedge core_clk);
    check("started", 8'(n_start - s0), exp_s);
    check("discarded", 8'(n_disc - d0), exp_d);
    check("busy_stby", {6'h00, busy, standby}, exp_s[0] ? 8'h02 : 8'h01);
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    check("standby", {7'h00, standby}, 8'h01);
  endtask : t_cmd
  task automatic t_wp(input logic level);
    @(posedge core_clk);
    #1 wp_n = level;
    repeat (4) @(posedge core_clk);
  endtask : t_wp
  initial begin
    repeat (3) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge core_clk);
    check("idle", {6'h00, busy, standby}, 8'h01);
    t_status(8'h00);
    t_cmd(8'h02, 3'h0, 32, 8'h01, 8'h00);
    t_cmd(8'h20, 3'h3, 32, 8'h01, 8'h00);
    t_cmd(8'h36, 3'h1, 32, 8'h00, 8'h00);
    t_wp(1'b0);
    t_status(8'h01);
    t_cmd(8'h02, 3'h1, 32, 8'h00, 8'h01);
    t_cmd(8'h20, 3'h0, 32, 8'h01, 8'h00);
    t_cmd(8'h7F, 3'h2, 32, 8'h00, 8'h00);
    t_cmd(8'h3D, 3'h0, 32, 8'h00, 8'h00);
    t_cmd(8'h3E, 3'h0, 32, 8'h00, 8'h00);
    t_status(8'h03);
    t_wp(1'b1);
    t_cmd(8'h02, 3'h2, 32, 8'h00, 8'h01);
    t_cmd(8'h02, 3'h1, 32, 8'h00, 8'h01);
    t_cmd(8'h02, 3'h0, 16, 8'h00, 8'h00);
    t_cmd(8'h02, 3'h0, 32, 8'h01, 8'h00);
    final_report();
  end
  // Fifteen frames of at most about 2 us each fit well inside this span
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule : testbench
